// >>> bench/status_output_selector_test.sv
// Self-checking bench for the status output selector
`timescale 1ns/1ns
`default_nettype none
module status_output_selector_test;
   logic ref_clk, sys_rst, start_cmd, halt_cmd, fire, trig;
   logic pin, wait_q, acq_q, clean_q, exp_q;
   status_out_pkg::cfg_t cfg;
   status_out_pkg::cam_status_t cam;
   logic [15:0] frame_target;
   logic note_q[$];
   int fail_count, checks_done, cleans, c0, i, s;

   status_out_sel #(.FRAME_W(16)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .cfg(cfg),
      .frame_target(frame_target), .start_cmd(start_cmd), .halt_cmd(halt_cmd), .cam(cam),
      .external_trigger_input(trig), .logic_out_q(pin), .trigger_wait_indicator_q(wait_q),
      .acquiring_q(acq_q), .clean_start_q(clean_q), .expose_start_q(exp_q));
   trig_source #(.LAG(2)) partner (.ref_clk(ref_clk), .fire(fire), .trig_pin(trig));

   // 10 MHz clock
   initial begin
      ref_clk = 1'h0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic chk(input string name, input logic seen, input logic exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %b seen %b", name, exp, seen);
      end
   endtask : chk

   task automatic stop_test();
      if (fail_count == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test

   // Lets one edge sample the inputs, notes the pin level due after it
   task automatic st(input logic e);
      @(posedge ref_clk);
      note_q.push_back(e);
      @(negedge ref_clk);
   endtask : st

   // Monitor: pin compared with the oldest note where it has settled
   always @(negedge ref_clk) begin
      if (clean_q === 1'h1) cleans++;
      if (note_q.size() > 0) chk("logic_out_q", pin, note_q.pop_front());
   end

   // Bounded wait for a sequencer request; a hang ends the run
   task automatic wait_hi(input bit on_exp);
      int n;
      n = 0;
      while (((on_exp ? exp_q : clean_q) !== 1'h1) && n < 20) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 20) begin
         fail_count++;
         stop_test();
      end
   endtask : wait_hi

   task automatic rst();
      sys_rst = 1'h1;
      cam = '0;
      repeat (4) @(negedge ref_clk);
      chk("pin_in_reset", pin, 1'h0);
      sys_rst = 1'h0;
      st(cfg.invert ^ (cfg.source == status_out_pkg::SRC_ALWAYS_HIGH));
   endtask : rst

   task automatic acq_go();
      start_cmd = 1'h1;
      st(1'h0);
      start_cmd = 1'h0;
      st(1'h0);
      cam.exposure_begin = 1'h1;
      st(1'h1);
      cam.exposure_begin = 1'h0;
   endtask : acq_go

   task automatic frame(input logic e);
      cam.frame_done = 1'h1;
      st(e);
      chk("acquiring_q", acq_q, e);
      cam.frame_done = 1'h0;
      st(e);
   endtask : frame

   initial begin
      sys_rst = 1'h1;
      start_cmd = 1'h0;
      halt_cmd = 1'h0;
      fire = 1'h0;
      cfg = '0;
      cam = '0;
      frame_target = 16'h0003;
      fail_count = 0;
      checks_done = 0;
      cleans = 0;
      i = $urandom(30);
      cfg.invert = 1'h1;
      repeat (8) @(negedge ref_clk);
      rst();
      // Level sources in both polarities, undefined codes give the idle level
      for (s = 2; s < 8; s++) begin
         for (i = 0; i < 8 && s != 5; i++) begin
            cfg.source = status_out_pkg::src_sel_t'(s[2:0]);
            cfg.invert = i[0];
            cam = status_out_pkg::cam_status_t'(10'($urandom()) & 10'h245);
            st(i[0] ^ (s == 2 | (s == 3 & cam.readout_active) | (s == 4 & cam.gate_on)));
         end
      end
      // Each sensor type answers only to its own shift indication
      cfg.source = status_out_pkg::SRC_MASK_SHIFT;
      cfg.invert = 1'h0;
      for (s = 0; s < 4; s++) begin
         cfg.sensor = status_out_pkg::sensor_t'(s[1:0]);
         cam = '0;
         cam.mask_shift_active = 1'h1;
         st(s == 0);
         cam = '0;
         cam.line_shift = 1'h1;
         st(s == 1);
         cam = '0;
         cam.storage_xfer_active = 1'h1;
         st(s == 2);
         cam = '0;
         st(1'h0);
      end
      // Counted acquisition ends on the third frame, focus mode only on halt
      rst();
      cfg.source = status_out_pkg::SRC_ACQUIRING;
      acq_go();
      for (i = 0; i < 3; i++) frame(i != 2);
      cfg.focus_mode = 1'h1;
      acq_go();
      for (i = 0; i < 4; i++) frame(1'h1);
      halt_cmd = 1'h1;
      st(1'h0);
      halt_cmd = 1'h0;
      // Pre-open delays the wait indication; trigger ends it
      rst();
      cfg.source = status_out_pkg::SRC_TRIG_WAIT;
      cfg.preopen_en = 1'h1;
      cam.readout_done = 1'h1;
      st(1'h0);
      cam.readout_done = 1'h0;
      cam.preopen_done = 1'h1;
      st(1'h1);
      cam.preopen_done = 1'h0;
      st(1'h1);
      fire = 1'h1;
      wait_hi(1'h1);
      chk("pin_at_expose", pin, 1'h0);
      fire = 1'h0;
      // Trigger during a clean waits for the clean to finish
      rst();
      cfg.preopen_en = 1'h0;
      cfg.cont_clean_en = 1'h1;
      cam.readout_done = 1'h1;
      st(1'h1);
      cam.readout_done = 1'h0;
      wait_hi(1'h0);
      // Short trigger, gone from the pin long before the clean ends
      fire = 1'h1;
      for (i = 0; i < 12; i++) begin
         @(negedge ref_clk);
         if (i == 2) begin
            fire = 1'h0;
         end
         chk("early_expose", exp_q, 1'h0);
         chk("second_clean", clean_q, 1'h0);
         chk("wait_in_clean", wait_q, 1'h1);
      end
      cam.clean_done = 1'h1;
      st(1'h1);
      cam.clean_done = 1'h0;
      wait_hi(1'h1);
      chk("pin_after_clean", pin, 1'h0);
      // Trigger already present at the check skips the clean
      rst();
      fire = 1'h1;
      repeat (4) @(negedge ref_clk);
      c0 = cleans;
      cam.readout_done = 1'h1;
      @(negedge ref_clk);
      cam.readout_done = 1'h0;
      wait_hi(1'h1);
      chk("clean_skipped", cleans == c0, 1'h1);
      fire = 1'h0;
      stop_test();
   end
endmodule : status_output_selector_test
`default_nettype wire

// >>> bench/trig_source.sv
// External equipment model that fires the trigger pin on request
`timescale 1ns/1ns
`default_nettype none
module trig_source #(
   parameter int LAG = 1
) (
   // Clock
   input wire logic ref_clk,
   // Bench request, held as a level
   input wire logic fire,
   // Trigger pin toward the camera
   output logic trig_pin
);
   logic [7:0] lag_q;
   // Request taken on the rising edge, where the bench holds it steady
   always @(posedge ref_clk) begin
      lag_q <= {lag_q[6:0], fire};
   end
   // Pin follows late and off the sampling edge, as slow gear would
   always @(negedge ref_clk) begin
      trig_pin <= lag_q[LAG-1];
   end
endmodule : trig_source
`default_nettype wire

// >>> inc/status_out_pkg.sv
// Shared types and constants for the status output selector
`default_nettype none
package status_out_pkg;

   // Width of the source selector and of the sensor type field
   localparam int SRC_W = 3;
   localparam int SENSOR_W = 2;

   // Default width of the programmed frame count
   localparam int FRAME_W_DEF = 16;

   // Reset level of the status pin and of every internal flag
   localparam logic OUT_RST = 1'h0;
   localparam logic FLAG_RST = 1'h0;

   // Selectable status sources
   typedef enum logic [SRC_W-1:0] {
      SRC_ACQUIRING = 3'h0,
      SRC_MASK_SHIFT = 3'h1,
      SRC_ALWAYS_HIGH = 3'h2,
      SRC_READOUT = 3'h3,
      SRC_GATE_ON = 3'h4,
      SRC_TRIG_WAIT = 3'h5
   } src_sel_t;

   // Sensor architecture, decides mask-shift timing
   typedef enum logic [SENSOR_W-1:0] {
      SENSOR_INTERLINE = 2'h0,
      SENSOR_FULL_FRAME = 2'h1,
      SENSOR_FRAME_XFER = 2'h2
   } sensor_t;

   // Acquisition tracker states
   typedef enum logic [1:0] {
      ACQ_IDLE = 2'h0,
      ACQ_PRECLEAN = 2'h1,
      ACQ_RUN = 2'h2
   } acq_state_t;

   // Trigger sequencer states
   typedef enum logic [2:0] {
      TRG_IDLE = 3'h0,
      TRG_PREOPEN = 3'h1,
      TRG_WAIT = 3'h2,
      TRG_CLEAN = 3'h3,
      TRG_EXPOSE = 3'h4
   } trg_state_t;

   // Software configuration
   typedef struct packed {
      src_sel_t source;
      logic invert;
      sensor_t sensor;
      logic focus_mode;
      logic cont_clean_en;
      logic preopen_en;
   } cfg_t;

   // Camera status from the sequencer, same clock
   typedef struct packed {
      logic readout_active;
      logic readout_done;
      logic preopen_done;
      logic gate_on;
      logic exposure_begin;
      logic frame_done;
      logic clean_done;
      logic mask_shift_active;
      logic line_shift;
      logic storage_xfer_active;
   } cam_status_t;

endpackage : status_out_pkg
`default_nettype wire

// >>> logic/status_out_sel.sv
// Camera status selector driving the logic-level status pin
`timescale 1ns/1ns
`default_nettype none
module status_out_sel #(
   parameter int FRAME_W = status_out_pkg::FRAME_W_DEF
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Configuration and commands
   input wire status_out_pkg::cfg_t cfg,
   input wire logic [FRAME_W-1:0] frame_target,
   input wire logic start_cmd,
   input wire logic halt_cmd,
   // Camera status
   input wire status_out_pkg::cam_status_t cam,
   // External trigger pin, asynchronous
   input wire logic external_trigger_input,
   // Status pin and sequencer requests
   output logic logic_out_q,
   output logic trigger_wait_indicator_q,
   output logic acquiring_q,
   output logic clean_start_q,
   output logic expose_start_q
);

   // Counter wider than a word is not served by the compare logic
   if (FRAME_W < 1 || FRAME_W > 32) begin : g_frame_w_check
      $error("FRAME_W out of range");
   end

   // Apply polarity to a condition
   function automatic logic polarity(input logic active, input logic inv);
      polarity = active ^ inv;
   endfunction : polarity

   // Trigger pin synchroniser, first stage read only by second
   logic trig_meta_q;
   logic trig_sync_q;
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         trig_meta_q <= status_out_pkg::FLAG_RST;
         trig_sync_q <= status_out_pkg::FLAG_RST;
      end else begin
         trig_meta_q <= external_trigger_input;
         trig_sync_q <= trig_meta_q;
      end
   end

   // Acquisition tracker
   status_out_pkg::acq_state_t acq_q, acq_d;
   logic [FRAME_W-1:0] frames_q, frames_d;
   logic last_frame;
   always_comb begin
      acq_d = acq_q;
      frames_d = frames_q;
      last_frame = (frames_q + FRAME_W'(1)) >= frame_target;
      case (acq_q)
         status_out_pkg::ACQ_IDLE: begin
            if (start_cmd) begin
               acq_d = status_out_pkg::ACQ_PRECLEAN;
               frames_d = '0;
            end
         end
         status_out_pkg::ACQ_PRECLEAN: begin
            if (cam.exposure_begin) begin
               acq_d = status_out_pkg::ACQ_RUN;
            end
         end
         status_out_pkg::ACQ_RUN: begin
            if (cam.frame_done) begin
               frames_d = frames_q + FRAME_W'(1);
               if (!cfg.focus_mode && last_frame) begin
                  acq_d = status_out_pkg::ACQ_IDLE;
               end
            end
         end
         default: begin
            acq_d = status_out_pkg::ACQ_IDLE;
         end
      endcase
      // Halt ends any acquisition, the only exit in focus mode
      if (halt_cmd) begin
         acq_d = status_out_pkg::ACQ_IDLE;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         acq_q <= status_out_pkg::ACQ_IDLE;
         frames_q <= '0;
      end else begin
         acq_q <= acq_d;
         frames_q <= frames_d;
      end
   end

   // Trigger sequencer; a trigger seen mid-clean is held for the next check
   status_out_pkg::trg_state_t trg_q, trg_d;
   logic trig_seen_q, trig_seen_d;
   logic clean_start_d, expose_start_d;
   logic trig_now;
   always_comb begin
      trg_d = trg_q;
      clean_start_d = 1'h0;
      expose_start_d = 1'h0;
      trig_now = trig_sync_q | trig_seen_q;
      trig_seen_d = trig_seen_q;
      case (trg_q)
         status_out_pkg::TRG_IDLE: begin
            if (cam.readout_done || start_cmd) begin
               if (cfg.preopen_en) begin
                  trg_d = status_out_pkg::TRG_PREOPEN;
               end else begin
                  trg_d = status_out_pkg::TRG_WAIT;
               end
            end
         end
         status_out_pkg::TRG_PREOPEN: begin
            if (cam.preopen_done) begin
               trg_d = status_out_pkg::TRG_WAIT;
            end
         end
         status_out_pkg::TRG_WAIT: begin
            if (trig_now) begin
               trg_d = status_out_pkg::TRG_EXPOSE;
               expose_start_d = 1'h1;
               trig_seen_d = 1'h0;
            end else if (cfg.cont_clean_en) begin
               trg_d = status_out_pkg::TRG_CLEAN;
               clean_start_d = 1'h1;
            end
         end
         status_out_pkg::TRG_CLEAN: begin
            // Clean always completes before the trigger is acted on; a trigger seen meanwhile is latched
            if (trig_sync_q) begin
               trig_seen_d = 1'h1;
            end
            if (cam.clean_done) begin
               trg_d = status_out_pkg::TRG_WAIT;
            end
         end
         status_out_pkg::TRG_EXPOSE: begin
            if (cam.frame_done || halt_cmd) begin
               trg_d = status_out_pkg::TRG_IDLE;
            end
         end
         default: begin
            trg_d = status_out_pkg::TRG_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         trg_q <= status_out_pkg::TRG_IDLE;
         trig_seen_q <= status_out_pkg::FLAG_RST;
         clean_start_q <= status_out_pkg::FLAG_RST;
         expose_start_q <= status_out_pkg::FLAG_RST;
      end else begin
         trg_q <= trg_d;
         trig_seen_q <= trig_seen_d;
         clean_start_q <= clean_start_d;
         expose_start_q <= expose_start_d;
      end
   end

   // Source decode and output register
   logic wait_d, acq_level_d, shift_raw, raw_d, out_d;
   always_comb begin
      // Waiting covers the check and the cleaning between checks
      wait_d = (trg_d == status_out_pkg::TRG_WAIT) || (trg_d == status_out_pkg::TRG_CLEAN);
      acq_level_d = (acq_d == status_out_pkg::ACQ_RUN);
      case (cfg.sensor)
         status_out_pkg::SENSOR_INTERLINE: shift_raw = cam.mask_shift_active;
         status_out_pkg::SENSOR_FULL_FRAME: shift_raw = cam.line_shift;
         status_out_pkg::SENSOR_FRAME_XFER: shift_raw = cam.storage_xfer_active;
         default: shift_raw = 1'h0;
      endcase
      case (cfg.source)
         status_out_pkg::SRC_ACQUIRING: raw_d = acq_level_d;
         status_out_pkg::SRC_MASK_SHIFT: raw_d = shift_raw;
         status_out_pkg::SRC_ALWAYS_HIGH: raw_d = 1'h1;
         status_out_pkg::SRC_READOUT: raw_d = cam.readout_active;
         status_out_pkg::SRC_GATE_ON: raw_d = cam.gate_on;
         status_out_pkg::SRC_TRIG_WAIT: raw_d = wait_d;
         default: raw_d = 1'h0;
      endcase
      out_d = polarity(raw_d, cfg.invert);
   end

   // One register stage keeps the pin glitch free
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         logic_out_q <= status_out_pkg::OUT_RST;
         trigger_wait_indicator_q <= status_out_pkg::FLAG_RST;
         acquiring_q <= status_out_pkg::FLAG_RST;
      end else begin
         logic_out_q <= out_d;
         trigger_wait_indicator_q <= wait_d;
         acquiring_q <= acq_level_d;
      end
   end

   // Checks
   property p_readout_level;
      @(posedge ref_clk) disable iff (sys_rst)
      (cfg.source == status_out_pkg::SRC_READOUT) ##1 (cfg.source == status_out_pkg::SRC_READOUT)
         |-> logic_out_q == ($past(cam.readout_active) ^ $past(cfg.invert));
   endproperty
   a_readout_level: assert property (p_readout_level) else $error("readout level wrong");

   property p_gate_level;
      @(posedge ref_clk) disable iff (sys_rst)
      (cfg.source == status_out_pkg::SRC_GATE_ON && !cfg.invert && cam.gate_on) |=> logic_out_q;
   endproperty
   a_gate_level: assert property (p_gate_level) else $error("gate level not high");

   property p_always_high;
      @(posedge ref_clk) disable iff (sys_rst)
      (cfg.source == status_out_pkg::SRC_ALWAYS_HIGH && !cfg.invert)[*2] |-> logic_out_q;
   endproperty
   a_always_high: assert property (p_always_high) else $error("constant source not high");

   property p_invert_high;
      @(posedge ref_clk) disable iff (sys_rst)
      (cfg.source == status_out_pkg::SRC_ALWAYS_HIGH && cfg.invert) |=> !logic_out_q;
   endproperty
   a_invert_high: assert property (p_invert_high) else $error("inverted output wrong");

   property p_start_low;
      @(posedge ref_clk) disable iff (sys_rst)
      (acq_q == status_out_pkg::ACQ_IDLE && start_cmd && !halt_cmd) |=> !acquiring_q ##0
         (acq_q == status_out_pkg::ACQ_PRECLEAN);
   endproperty
   a_start_low: assert property (p_start_low) else $error("acquiring rose during cleaning");

   property p_focus_hold;
      @(posedge ref_clk) disable iff (sys_rst)
      (acq_q == status_out_pkg::ACQ_RUN && cfg.focus_mode && !halt_cmd) |=> acquiring_q;
   endproperty
   a_focus_hold: assert property (p_focus_hold) else $error("focus acquisition dropped");

   property p_trig_expose;
      @(posedge ref_clk) disable iff (sys_rst)
      (trg_q == status_out_pkg::TRG_WAIT && trig_sync_q) |=> expose_start_q && !trigger_wait_indicator_q;
   endproperty
   a_trig_expose: assert property (p_trig_expose) else $error("trigger not acted on");

   property p_clean_hold;
      @(posedge ref_clk) disable iff (sys_rst)
      (trg_q == status_out_pkg::TRG_CLEAN && !cam.clean_done) |=> trg_q == status_out_pkg::TRG_CLEAN
         && !expose_start_q;
   endproperty
   a_clean_hold: assert property (p_clean_hold) else $error("clean cut short");

   property p_wait_rise;
      @(posedge ref_clk) disable iff (sys_rst)
      (trg_q == status_out_pkg::TRG_IDLE && cam.readout_done && !cfg.preopen_en) |=> trigger_wait_indicator_q;
   endproperty
   a_wait_rise: assert property (p_wait_rise) else $error("wait indicator late");

   property p_reset_low;
      @(posedge ref_clk) sys_rst |=> !logic_out_q;
   endproperty
   a_reset_low: assert property (p_reset_low) else $error("output not low after reset");

   property p_wait_level;
      @(posedge ref_clk) disable iff (sys_rst)
      (trg_q == status_out_pkg::TRG_WAIT && !trig_now && !cfg.cont_clean_en) |=> trigger_wait_indicator_q;
   endproperty
   a_wait_level: assert property (p_wait_level) else $error("wait indicator dropped");

   property p_preopen_rise;
      @(posedge ref_clk) disable iff (sys_rst)
      (trg_q == status_out_pkg::TRG_PREOPEN && cam.preopen_done) |=> trigger_wait_indicator_q;
   endproperty
   a_preopen_rise: assert property (p_preopen_rise) else $error("wait indicator late after pre-open");

   property p_frames_end;
      @(posedge ref_clk) disable iff (sys_rst)
      (acq_q == status_out_pkg::ACQ_RUN && cam.frame_done && !cfg.focus_mode && last_frame) |=> !acquiring_q;
   endproperty
   a_frames_end: assert property (p_frames_end) else $error("acquiring high after last frame");

   property p_line_pulse;
      @(posedge ref_clk) disable iff (sys_rst)
      (cfg.source == status_out_pkg::SRC_MASK_SHIFT && cfg.sensor == status_out_pkg::SENSOR_FULL_FRAME
         && !cfg.invert) |=> logic_out_q == $past(cam.line_shift);
   endproperty
   a_line_pulse: assert property (p_line_pulse) else $error("line pulse not passed through");

endmodule : status_out_sel
`default_nettype wire
